// >>> rtl/flash_seq_defs.svh
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// ======================================================================
// Opcodes
`define OP_NONE        8'h00
`define OP_STAT_WRITE  8'h01
`define OP_PROG        8'h02
`define OP_READ        8'h03
`define OP_WDIS        8'h04
`define OP_STAT_READ   8'h05
`define OP_WEN         8'h06
`define OP_FAST_READ   8'h0b
`define OP_SECT_ERASE  8'h20
`define OP_STAT_WEN    8'h50
`define OP_BLK_ERASE   8'h52
`define OP_CHIP_ERASE  8'h60
`define OP_ID_A        8'h90
`define OP_ID_B        8'hab
`define OP_AAI         8'haf

// ======================================================================
// Address space and erase geometry
`define ADDR_W     18
`define ADDR_TOP   18'h3ffff
`define ADDR_ZERO  18'h00000
`define SECT_MASK  18'h3f000
`define BLK_MASK   18'h38000
`define QTR_TOP    2'h3
`define MEM_DEPTH  262144
`define ERASED     8'hff

// ======================================================================
// Bus cycle framing: last bit within a byte, index of the byte within an instruction
`define LAST_BIT   3'h7
`define IDX_OP     3'h0
`define IDX_A2     3'h1
`define IDX_A0     3'h3
`define IDX_B4     3'h4
`define IDX_SAT    3'h7

// ======================================================================
// Status byte layout and protection levels
`define ST_BUSY    0
`define ST_WEL     1
`define ST_BP0     2
`define ST_BP1     3
`define ST_AAI     6
`define ST_BPL     7
`define PROT_NONE  2'h0
`define PROT_QTR   2'h1
`define PROT_HALF  2'h2
`define BP_RESET   2'h3

// ======================================================================
// Timing and identity (identity values are arbitrary)
`define MCLK_NS      50
`define PROG_NS_DEF  20000
`define SECT_NS_DEF  25000000
`define BLK_NS_DEF   25000000
`define CHIP_NS_DEF  100000000
`define MAKER_ID     8'h5a
`define PART_ID      8'h3c

`endif

// >>> rtl/flash_seq_pkg.sv
`default_nettype none
package flash_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROG  = 2'b01,
    ST_ERASE = 2'b10
  } exec_state_t;

  typedef enum logic [1:0] {
    OUT_NONE = 2'b00,
    OUT_MEM  = 2'b01,
    OUT_STAT = 2'b10,
    OUT_ID   = 2'b11
  } link_out_t;

endpackage : flash_seq_pkg
`default_nettype wire

// >>> rtl/spi_flash_command_sequencer.sv
// Behaviour
// - Read 03H, three address bytes, then data.
// - Reads stream bytes until select rises.
// - Read pointer increments, wraps top to zero.
// - Fast read 0BH, address, one dummy byte.
// - Dummy byte ignored; data after eight clocks.
// - Every bus cycle is eight clocks.
// - Address bits above bit 17 ignored.
// - Programs and erases rejected unless write enable latched.
// - Byte program 02H executes on select rise.
// - Self-timed operations show busy until done.
// - Programs into protected range are ignored.
// - AFH with address starts auto-increment mode.
// - AFH plus data programs next location.
// - Write disable ends auto-increment programming.
// - Auto-increment stops at top unprotected address.
// - Sector erase 20H clears 4K sector.
// - Block erase 52H clears 32K block.
// - Protected sector or block erase discarded.
// - Chip erase 60H ignored if any protection.
// - Status write only right after its enable.
// - Status read repeats every eight clocks.
// - Identity read alternates bytes, A0 picks first.
// - Inputs sampled on rising clock, MSB first.
// - Early select rise abandons the instruction.
// - Write disable clears latch and auto mode.
// - Write enable 06H sets the latch.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_defs.svh"

module spi_flash_command_sequencer #(
  parameter int PROG_NS = `PROG_NS_DEF,
  parameter int SECT_NS = `SECT_NS_DEF,
  parameter int BLK_NS = `BLK_NS_DEF,
  parameter int CHIP_NS = `CHIP_NS_DEF
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic SCK,
  input wire logic CE_N,
  input wire logic SI,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE,
  output logic BUSY
);

  localparam int PROG_CYC = (PROG_NS + `MCLK_NS - 1) / `MCLK_NS;
  localparam int SECT_CYC = (SECT_NS + `MCLK_NS - 1) / `MCLK_NS;
  localparam int BLK_CYC = (BLK_NS + `MCLK_NS - 1) / `MCLK_NS;
  localparam int CHIP_CYC = (CHIP_NS + `MCLK_NS - 1) / `MCLK_NS;

  // Array is written only in the MCLK domain while busy; the link reads it only when
  // not busy, so it is quasi-static whenever the link looks at it.
  logic [7:0] mem [0:`MEM_DEPTH-1];

  function automatic logic is_prot(input logic [`ADDR_W-1:0] a, input logic [1:0] lvl);
    case (lvl)
      `PROT_NONE: is_prot = 1'b0;
      `PROT_QTR: is_prot = (a[`ADDR_W-1:`ADDR_W-2] == `QTR_TOP);
      `PROT_HALF: is_prot = a[`ADDR_W-1];
      default: is_prot = 1'b1;
    endcase
  endfunction : is_prot

  // ======================================================================
  // Link domain (SCK); framing and output registers held in reset while select is high, status and snapshot only by SYS_RST
  logic link_rst;
  assign link_rst = CE_N | SYS_RST;

  logic [2:0] bit_q;
  logic [2:0] idx_q;
  logic [6:0] sh_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [`ADDR_W-1:0] ptr_q;
  logic [7:0] tx_q;
  logic id_sel_q;
  flash_seq_pkg::link_out_t out_q;
  logic [7:0] stat_q;
  logic [7:0] stat_m_q;
  logic [7:0] stat_s_q;

  logic [7:0] byte_in;
  logic byte_end;
  logic [`ADDR_W-1:0] full_addr;
  logic busy_s;
  logic aai_s;
  logic [7:0] op_eff;
  logic [2:0] last_idx;
  logic fire;
  logic load_mem;
  logic [`ADDR_W-1:0] rd_idx;

  always_comb begin
    byte_in = {sh_q, SI};
    byte_end = (bit_q == `LAST_BIT);
    full_addr = {addr_q[`ADDR_W-9:0], byte_in};
    busy_s = stat_s_q[`ST_BUSY];
    aai_s = stat_s_q[`ST_AAI];
    op_eff = op_q;
    if (idx_q == `IDX_OP) begin
      op_eff = (busy_s && byte_in != `OP_STAT_READ) ? `OP_NONE : byte_in;
    end
    case (op_eff)
      `OP_STAT_WRITE: last_idx = `IDX_A2;
      `OP_PROG: last_idx = `IDX_B4;
      `OP_AAI: last_idx = aai_s ? `IDX_A2 : `IDX_B4;
      `OP_SECT_ERASE, `OP_BLK_ERASE: last_idx = `IDX_A0;
      default: last_idx = `IDX_OP;
    endcase
    fire = byte_end && (idx_q == last_idx) && (op_eff != `OP_NONE);
    load_mem = byte_end && ((out_q == flash_seq_pkg::OUT_MEM) ||
               (out_q == flash_seq_pkg::OUT_NONE && op_q == `OP_READ && idx_q == `IDX_A0) ||
               (out_q == flash_seq_pkg::OUT_NONE && op_q == `OP_FAST_READ && idx_q == `IDX_B4));
    rd_idx = (out_q == flash_seq_pkg::OUT_NONE && op_q == `OP_READ) ? full_addr : ptr_q;
  end

  always_ff @(posedge SCK or posedge link_rst) begin
    if (link_rst) begin
      bit_q <= 3'h0;
      idx_q <= `IDX_OP;
      sh_q <= 7'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q <= byte_in[6:0];
      if (byte_end && idx_q != `IDX_SAT) begin
        idx_q <= idx_q + 3'h1;
      end
    end
  end

  always_ff @(posedge SCK or posedge link_rst) begin
    if (link_rst) begin
      op_q <= `OP_NONE;
      addr_q <= 24'h000000;
      ptr_q <= `ADDR_ZERO;
      tx_q <= 8'h00;
      id_sel_q <= 1'b0;
      out_q <= flash_seq_pkg::OUT_NONE;
    end else if (byte_end) begin
      if (idx_q == `IDX_OP) begin
        op_q <= op_eff;
      end
      if (idx_q >= `IDX_A2 && idx_q <= `IDX_A0) begin
        addr_q <= {addr_q[15:0], byte_in};
      end
      if (load_mem) begin
        tx_q <= mem[rd_idx];
        ptr_q <= rd_idx + 18'h00001;
        out_q <= flash_seq_pkg::OUT_MEM;
      end else if (out_q == flash_seq_pkg::OUT_STAT) begin
        tx_q <= stat_s_q;
      end else if (out_q == flash_seq_pkg::OUT_ID) begin
        tx_q <= id_sel_q ? `PART_ID : `MAKER_ID;
        id_sel_q <= ~id_sel_q;
      end else if (idx_q == `IDX_OP && op_eff == `OP_STAT_READ) begin
        tx_q <= stat_s_q;
        out_q <= flash_seq_pkg::OUT_STAT;
      end else if (idx_q == `IDX_A0 && op_q == `OP_FAST_READ) begin
        ptr_q <= full_addr;
      end else if (idx_q == `IDX_A0 && (op_q == `OP_ID_A || op_q == `OP_ID_B)) begin
        tx_q <= full_addr[0] ? `PART_ID : `MAKER_ID;
        id_sel_q <= ~full_addr[0];
        out_q <= flash_seq_pkg::OUT_ID;
      end
    end
  end

  // Output changes on the falling edge and floats outside data phases
  always_ff @(negedge SCK or posedge link_rst) begin
    if (link_rst) begin
      SO <= 1'b0;
      SO_OE <= 1'b0;
    end else begin
      SO <= tx_q[~bit_q];
      SO_OE <= (out_q != flash_seq_pkg::OUT_NONE);
    end
  end

  // Status crosses as a multi-bit level; it only moves while SCK is idle or busy,
  // and a status read samples it at least eight edges after select falls.
  always_ff @(posedge SCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stat_m_q <= 8'h00;
      stat_s_q <= 8'h00;
    end else begin
      stat_m_q <= stat_q;
      stat_s_q <= stat_m_q;
    end
  end

  // Snapshot of a complete instruction, kept across select rise
  logic [7:0] s_op_q;
  logic [`ADDR_W-1:0] s_addr_q;
  logic [7:0] s_data_q;
  logic s_tgl_q;

  always_ff @(posedge SCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_op_q <= `OP_NONE;
      s_addr_q <= `ADDR_ZERO;
      s_data_q <= 8'h00;
      s_tgl_q <= 1'b0;
    end else if (fire && !CE_N) begin
      s_op_q <= op_eff;
      s_addr_q <= (idx_q == `IDX_A0) ? full_addr : addr_q[`ADDR_W-1:0];
      s_data_q <= byte_in;
      s_tgl_q <= ~s_tgl_q;
    end
  end

  // ======================================================================
  // Core domain (MCLK)
  logic tgl_m_q, tgl_s_q, tgl_d_q;
  logic ce_m_q, ce_s_q;
  logic wp_m_q, wp_s_q;
  logic pend_q;
  logic [7:0] x_op_q;
  logic [`ADDR_W-1:0] x_addr_q;
  logic [7:0] x_data_q;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tgl_m_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_d_q <= 1'b0;
      ce_m_q <= 1'b1;
      ce_s_q <= 1'b1;
      wp_m_q <= 1'b0;
      wp_s_q <= 1'b0;
    end else begin
      tgl_m_q <= s_tgl_q;
      tgl_s_q <= tgl_m_q;
      tgl_d_q <= tgl_s_q;
      ce_m_q <= CE_N;
      ce_s_q <= ce_m_q;
      wp_m_q <= WP_N;
      wp_s_q <= wp_m_q;
    end
  end

  logic new_cmd;
  logic exec;
  logic busy_q;
  assign new_cmd = tgl_s_q ^ tgl_d_q;
  assign exec = pend_q && ce_s_q && !busy_q;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend_q <= 1'b0;
      x_op_q <= `OP_NONE;
      x_addr_q <= `ADDR_ZERO;
      x_data_q <= 8'h00;
    end else begin
      if (new_cmd) begin
        pend_q <= 1'b1;
        x_op_q <= s_op_q;
        x_addr_q <= s_addr_q;
        x_data_q <= s_data_q;
      end else if (ce_s_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  logic wel_q, aai_q, armed_q, bpl_q;
  logic [1:0] bp_q;
  flash_seq_pkg::exec_state_t state_q;
  logic [`ADDR_W-1:0] waddr_q, er_ptr_q, er_end_q;
  logic er_run_q;
  logic [31:0] tmr_q;

  logic [`ADDR_W-1:0] aai_next;
  logic start_prog, start_erase, done;
  logic [`ADDR_W-1:0] tgt, er_lo, er_hi;
  logic [31:0] dur;

  always_comb begin
    aai_next = waddr_q + 18'h00001;
    start_prog = 1'b0;
    start_erase = 1'b0;
    tgt = x_addr_q;
    er_lo = x_addr_q & `SECT_MASK;
    er_hi = x_addr_q | ~`SECT_MASK;
    dur = 32'(PROG_CYC);
    if (exec && wel_q) begin
      case (x_op_q)
        `OP_PROG: start_prog = !is_prot(x_addr_q, bp_q);
        `OP_AAI: begin
          tgt = aai_q ? aai_next : x_addr_q;
          start_prog = !is_prot(tgt, bp_q);
        end
        `OP_SECT_ERASE: begin
          start_erase = !is_prot(x_addr_q, bp_q);
          dur = 32'(SECT_CYC);
        end
        `OP_BLK_ERASE: begin
          er_lo = x_addr_q & `BLK_MASK;
          er_hi = x_addr_q | ~`BLK_MASK;
          start_erase = !is_prot(x_addr_q, bp_q);
          dur = 32'(BLK_CYC);
        end
        `OP_CHIP_ERASE: begin
          er_lo = `ADDR_ZERO;
          er_hi = `ADDR_TOP;
          start_erase = (bp_q == `PROT_NONE);
          dur = 32'(CHIP_CYC);
        end
        default: start_prog = 1'b0;
      endcase
    end
    done = busy_q && (tmr_q == 32'h0) && !er_run_q;
  end

  // Self-timed engine; erase also sweeps the range one byte per cycle
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= flash_seq_pkg::ST_IDLE;
      busy_q <= 1'b0;
      waddr_q <= `ADDR_ZERO;
      er_ptr_q <= `ADDR_ZERO;
      er_end_q <= `ADDR_ZERO;
      er_run_q <= 1'b0;
      tmr_q <= 32'h0;
    end else begin
      case (state_q)
        flash_seq_pkg::ST_IDLE: begin
          if (start_prog || start_erase) begin
            busy_q <= 1'b1;
            tmr_q <= dur;
            state_q <= start_prog ? flash_seq_pkg::ST_PROG : flash_seq_pkg::ST_ERASE;
          end
          if (start_prog) begin
            waddr_q <= tgt;
          end
          if (start_erase) begin
            er_ptr_q <= er_lo;
            er_end_q <= er_hi;
            er_run_q <= 1'b1;
          end
        end
        flash_seq_pkg::ST_PROG, flash_seq_pkg::ST_ERASE: begin
          if (tmr_q != 32'h0) begin
            tmr_q <= tmr_q - 32'h1;
          end
          if (er_run_q) begin
            er_run_q <= (er_ptr_q != er_end_q);
            er_ptr_q <= er_ptr_q + 18'h00001;
          end
          if (done) begin
            busy_q <= 1'b0;
            state_q <= flash_seq_pkg::ST_IDLE;
          end
        end
        default: state_q <= flash_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Programming can only clear bits, so an unerased byte ANDs with the data
  always_ff @(posedge MCLK) begin
    if (start_prog) begin
      mem[tgt] <= mem[tgt] & x_data_q;
    end else if (er_run_q) begin
      mem[er_ptr_q] <= `ERASED;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wel_q <= 1'b0;
      aai_q <= 1'b0;
      armed_q <= 1'b0;
      bp_q <= `BP_RESET;
      bpl_q <= 1'b0;
    end else if (exec) begin
      armed_q <= (x_op_q == `OP_STAT_WEN);
      case (x_op_q)
        `OP_WEN: wel_q <= 1'b1;
        `OP_WDIS: begin
          wel_q <= 1'b0;
          aai_q <= 1'b0;
        end
        `OP_STAT_WRITE: begin
          if (armed_q && !(bpl_q && !wp_s_q)) begin
            bp_q <= {x_data_q[`ST_BP1], x_data_q[`ST_BP0]};
            bpl_q <= x_data_q[`ST_BPL];
          end
        end
        `OP_AAI: aai_q <= aai_q || start_prog;
        default: aai_q <= aai_q;
      endcase
    end else if (done) begin
      if (!aai_q) begin
        wel_q <= 1'b0;
      end else if (waddr_q == `ADDR_TOP || is_prot(aai_next, bp_q)) begin
        aai_q <= 1'b0;
        wel_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stat_q <= 8'h00;
      BUSY <= 1'b0;
    end else begin
      stat_q <= {bpl_q, aai_q, 2'b00, bp_q, wel_q, busy_q};
      BUSY <= busy_q;
    end
  end

  // ======================================================================
  // Checks
  property p_wen_sets;
    @(posedge MCLK) disable iff (SYS_RST) exec && x_op_q == `OP_WEN |=> wel_q;
  endproperty
  a_wen_sets: assert property (p_wen_sets)
    else $error("write enable did not set the latch");

  property p_wdis_clears;
    @(posedge MCLK) disable iff (SYS_RST) exec && x_op_q == `OP_WDIS |=> !wel_q && !aai_q;
  endproperty
  a_wdis_clears: assert property (p_wdis_clears)
    else $error("write disable left latch or auto mode set");

  property p_no_wel_no_op;
    @(posedge MCLK) disable iff (SYS_RST) exec && !wel_q |=> !busy_q;
  endproperty
  a_no_wel_no_op: assert property (p_no_wel_no_op)
    else $error("operation started without write enable");

  property p_busy_holds;
    @(posedge MCLK) disable iff (SYS_RST) start_prog |=> busy_q [*2];
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("busy not shown during program");

  property p_done_clears_wel;
    @(posedge MCLK) disable iff (SYS_RST) $fell(busy_q) && !aai_q |-> !wel_q;
  endproperty
  a_done_clears_wel: assert property (p_done_clears_wel)
    else $error("latch still set after completion");

  property p_chip_prot;
    @(posedge MCLK) disable iff (SYS_RST)
      exec && x_op_q == `OP_CHIP_ERASE && bp_q != `PROT_NONE |=> !busy_q;
  endproperty
  a_chip_prot: assert property (p_chip_prot)
    else $error("chip erase ran with protection set");

  property p_unarmed_stat;
    @(posedge MCLK) disable iff (SYS_RST) exec && !armed_q |=> $stable({bpl_q, bp_q});
  endproperty
  a_unarmed_stat: assert property (p_unarmed_stat)
    else $error("protection changed without status write enable");

  property p_prog_unprot;
    @(posedge MCLK) disable iff (SYS_RST)
      exec && wel_q && x_op_q == `OP_PROG && is_prot(x_addr_q, bp_q) |=> !busy_q;
  endproperty
  a_prog_unprot: assert property (p_prog_unprot)
    else $error("program aimed at protected location");

  property p_read_wrap;
    @(posedge SCK) disable iff (link_rst) load_mem && rd_idx == `ADDR_TOP |=> ptr_q == `ADDR_ZERO;
  endproperty
  a_read_wrap: assert property (p_read_wrap)
    else $error("read pointer did not wrap to zero");

endmodule : spi_flash_command_sequencer

`default_nettype wire

// >>> rtl/flash_seq_pkg_note_none.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> bench/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Host side of the link: mode 0, clock stands low between frames
module spi_host_model (
  output logic SCK,
  output logic CE_N,
  output logic SI,
  input wire logic SO,
  input wire logic SO_OE
);
  logic tog_q = 1'b0;

  // A released output reads as tog_q, which flips on both SCK edges and so gives the same bit at every sample
  always @(SCK) tog_q <= ~tog_q;

  initial begin
    SCK = 1'b0;
    CE_N = 1'b1;
    SI = 1'b0;
  end

  // Gap before each frame keeps at least 10 core clocks between frames
  task automatic open_f();
    #600 CE_N = 1'b0;
    #62.5;
  endtask : open_f

  // 8 MHz serial clock, below both read limits; SI moves only while SCK is low
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      SI = tx[i];
      #62.5 SCK = 1'b1;
      rx = {rx[6:0], SO_OE ? SO : tog_q};
      #62.5 SCK = 1'b0;
    end
  endtask : bits

  task automatic close_f();
    #62.5 CE_N = 1'b1;
    SI = ~SI;
  endtask : close_f
endmodule : spi_host_model
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_defs.svh"
module tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic wp_n = 1'b1;
  logic sck, ce_n, si, so, so_oe, busy;
  logic [7:0] rdq [0:3];
  logic [7:0] d0, d1;
  logic [23:0] a;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;

  spi_flash_command_sequencer #(.PROG_NS(200), .SECT_NS(500), .BLK_NS(500), .CHIP_NS(500))
    dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .SCK(sck), .CE_N(ce_n), .SI(si), .WP_N(wp_n),
           .SO(so), .SO_OE(so_oe), .BUSY(busy));
  spi_host_model host_u (.SCK(sck), .CE_N(ce_n), .SI(si), .SO(so), .SO_OE(so_oe));

  // ==========
  // Clock and cycle ceiling
  initial begin
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      complete_run();
    end
  end

  // ==========
  // Checking and expectations
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  function automatic logic [7:0] st(input logic write_enable_latch, input logic [1:0] bp, input logic auto_increment_program);
    return {1'b0, auto_increment_program, 2'b00, bp, write_enable_latch, 1'b0};
  endfunction : st

  // Bits above the used address are random so they must not matter
  function automatic logic [23:0] junk(input logic [17:0] adr);
    return {6'($urandom), adr};
  endfunction : junk

  // ==========
  // Link transactions
  task automatic wr(input logic [7:0] op, input logic [23:0] adr, input int na, input int nd,
                    input logic [7:0] d);
    logic [7:0] x;
    host_u.open_f();
    host_u.bits(op, 8, x);
    for (int i = 0; i < na; i++) host_u.bits(adr[23 - 8 * i -: 8], 8, x);
    if (nd > 0) host_u.bits(d, 8, x);
    host_u.close_f();
  endtask : wr

  task automatic op(input logic [7:0] code);
    wr(code, 24'h0, 0, 0, 8'h00);
  endtask : op

  task automatic rd(input logic [7:0] code, input logic [23:0] adr, input int n);
    logic [7:0] x;
    host_u.open_f();
    host_u.bits(code, 8, x);
    if (code != 8'h05) begin
      for (int i = 0; i < 3; i++) host_u.bits(adr[23 - 8 * i -: 8], 8, x);
    end
    if (code == 8'h0b) host_u.bits(8'($urandom), 8, x);
    for (int i = 0; i < n; i++) host_u.bits(8'h00, 8, rdq[i]);
    host_u.close_f();
  endtask : rd

  task automatic stat(input logic [7:0] exp);
    rd(8'h05, 24'h0, 2);
    check("status", rdq[0], exp);
    check("status again", rdq[1], exp);
    // The select-driven clear lands in the update region, so let it settle
    #2;
    check("output enable idle", {7'h0, so_oe}, 8'h00);
  endtask : stat

  // Waits out a self-timed operation; a short status poll only fits erases
  task automatic fin(input logic exp_b, input bit poll);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge mclk);
      seen = (busy === 1'b1);
    end
    check("busy", {7'h0, seen}, {7'h0, exp_b});
    if (seen && poll) begin
      rd(8'h05, 24'h0, 1);
      check("busy bit", rdq[0] & 8'h01, 8'h01);
    end
    for (int i = 0; i < 40000 && busy !== 1'b0; i++) @(posedge mclk);
    #2;
  endtask : fin

  task automatic prog(input logic [17:0] adr, input logic [7:0] d, input logic ok);
    op(8'h06);
    wr(8'h02, junk(adr), 3, 1, d);
    fin(ok, 0);
  endtask : prog

  // ==========
  // Main sequence
  initial begin
    void'($urandom(86));
    repeat (16) @(posedge mclk);
    #2 sys_rst = 1'b0;
    stat(st(0, 2'h3, 0));
    host_u.open_f();
    host_u.bits(8'h06, 5, d0);
    host_u.close_f();
    stat(st(0, 2'h3, 0));
    op(8'h06);
    stat(st(1, 2'h3, 0));
    op(8'h60);
    fin(0, 0);
    op(8'h04);
    stat(st(0, 2'h3, 0));
    op(8'h50);
    op(8'h06);
    wr(8'h01, 24'h0, 0, 1, 8'h00);
    stat(st(1, 2'h3, 0));
    op(8'h50);
    wr(8'h01, 24'h0, 0, 1, 8'h00);
    rd(8'h05, 24'h0, 1);
    check("protect", rdq[0] & 8'h8c, 8'h00);
    op(8'h04);
    wr(8'h02, 24'h0, 3, 1, 8'h00);
    fin(0, 0);
    op(8'h06);
    wr(8'h20, junk(18'h00123), 3, 0, 8'h00);
    fin(1, 1);
    op(8'h06);
    wr(8'h20, junk(18'h3f800), 3, 0, 8'h00);
    fin(1, 1);
    op(8'h06);
    wr(8'h52, junk(18'h2abcd), 3, 0, 8'h00);
    fin(1, 1);
    stat(st(0, 2'h0, 0));
    rd(8'h03, junk(18'h28000), 1);
    check("block erased", rdq[0], 8'hff);
    for (int i = 0; i < 6; i++) begin
      a = {6'h0, 18'h00100 + 18'(i * 64) + 18'($urandom % 64)};
      d0 = 8'($urandom);
      prog(a[17:0], d0, 1);
      rd(8'h03, junk(a[17:0]), 1);
      check("program", rdq[0], d0);
    end
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    prog(18'h3ffff, d1, 1);
    prog(18'h00000, d0, 1);
    for (int k = 0; k < 2; k++) begin
      rd(k ? 8'h0b : 8'h03, junk(18'h3fffe), 3);
      check("wrap 0", rdq[0], 8'hff);
      check("wrap 1", rdq[1], d1);
      check("wrap 2", rdq[2], d0);
    end
    op(8'h50);
    wr(8'h01, 24'h0, 0, 1, 8'h04);
    prog(18'h3f010, 8'h00, 0);
    wr(8'h20, junk(18'h3f000), 3, 0, 8'h00);
    fin(0, 0);
    stat(st(1, 2'h1, 0));
    rd(8'h03, junk(18'h3f010), 1);
    check("protected byte", rdq[0], 8'hff);
    op(8'h06);
    wr(8'haf, junk(18'h2fffe), 3, 1, d0);
    fin(1, 0);
    stat(st(1, 2'h1, 1));
    wr(8'haf, 24'h0, 0, 1, d1);
    fin(1, 0);
    stat(st(0, 2'h1, 0));
    rd(8'h03, junk(18'h2fffe), 2);
    check("auto 0", rdq[0], d0);
    check("auto 1", rdq[1], d1);
    op(8'h06);
    wr(8'haf, junk(18'h00300), 3, 1, d1);
    fin(1, 0);
    wr(8'haf, 24'h0, 0, 1, d0);
    fin(1, 0);
    op(8'h04);
    stat(st(0, 2'h1, 0));
    wr(8'haf, 24'h0, 0, 1, 8'h00);
    fin(0, 0);
    rd(8'h03, junk(18'h00300), 3);
    check("auto next 0", rdq[0], d1);
    check("auto next 1", rdq[1], d0);
    check("auto ended", rdq[2], 8'hff);
    op(8'h06);
    wr(8'h20, junk(18'h01000), 3, 0, 8'h00);
    repeat (20) @(posedge mclk);
    wr(8'h02, junk(18'h00800), 3, 1, 8'h00);
    fin(1, 0);
    rd(8'h03, junk(18'h00800), 1);
    check("busy refused", rdq[0], 8'hff);
    rd(8'h90, 24'h0, 3);
    check("id 0", rdq[0], `MAKER_ID);
    check("id 1", rdq[1], `PART_ID);
    check("id 2", rdq[2], `MAKER_ID);
    rd(8'hab, 24'h1, 2);
    check("id 3", rdq[0], `PART_ID);
    check("id 4", rdq[1], `MAKER_ID);
    // With the protect pin low, a set lock bit freezes the protection fields
    @(posedge mclk);
    #2 wp_n = 1'b0;
    op(8'h50);
    wr(8'h01, 24'h0, 0, 1, 8'h84);
    op(8'h50);
    wr(8'h01, 24'h0, 0, 1, 8'h00);
    rd(8'h05, 24'h0, 1);
    check("locked protect", rdq[0] & 8'h8c, 8'h84);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
